// >>> hdl/dcdm_cfg.svh
// Constants of the driver chain datagram multiplexer
// Functional notes
// - Bits leave in the order their codes sit in memory, from location zero.
// - A full separate signal set exists for each of three motors.
// - Codes 0-5 coil A DAC bits, 6 coil A polarity, 7 coil A fast decay.
// - Codes 8-13 coil B DAC bits, 14 coil B polarity, 15 coil B fast decay.
// - Code 18 sends current motor direction, 0 up/ccw, 1 down/cw.
// - Code 19 sends current motor step bit.
// - Unused codes 20 to 31 send constant one.
// - Code 16 sends constant zero, code 17 constant one.
// - Next-motor flag below last driver index and below index 2 advances the motor index.
// - Next-motor flag at last driver index ends datagram, index back to zero.
// - All signals are snapshotted before sending; bits come only from snapshot.
`ifndef DCDM_CFG_SVH
`define DCDM_CFG_SVH
`define DCDM_CFG_DEPTH 64
`define DCDM_ADDR_W 6
`define DCDM_CODE_W 5
`define DCDM_ENTRY_W 6
`define DCDM_FLAG_BIT 5
`define DCDM_MOTORS 3
`define DCDM_CODE_COILB 5'h08
`define DCDM_CODE_ZERO 5'h10
`define DCDM_CODE_ONE 5'h11
`define DCDM_CODE_DIR 5'h12
`define DCDM_CODE_STEP 5'h13
`define DCDM_IDX_RESET 2'h0
`endif

// >>> hdl/dcdm_pkg.sv
// Types shared by the driver chain datagram multiplexer
package dcdm_pkg;
  // Per-motor control signal set
  typedef struct packed {
    logic [5:0] coilADac;
    logic coil_a_polarity;
    logic coil_a_fast_decay;
    logic [5:0] coilBDac;
    logic coil_b_polarity;
    logic coil_b_fast_decay;
    logic direction;
    logic step;
  } dcdm_motor_s;
  // Configuration entry: next_motor_flag above the code
  typedef struct packed {
    logic next_motor_flag;
    logic [4:0] code;
  } dcdm_entry_s;
  typedef enum logic [1:0] {DCDM_IDLE, DCDM_SNAP, DCDM_SEND} dcdm_state_e;
endpackage

// >>> hdl/dcdm_select.sv
// Combinational signal selector for one configuration code
`timescale 1ns/1ps
`include "dcdm_cfg.svh"
module dcdm_select
  import dcdm_pkg::*;
(
  input wire dcdm_motor_s motor,
  input wire logic [4:0] code,
  output logic bitOut
);
  wire [7:0] coilA = {motor.coil_a_fast_decay, motor.coil_a_polarity,
                      motor.coilADac};
  wire [7:0] coilB = {motor.coil_b_fast_decay, motor.coil_b_polarity,
                      motor.coilBDac};
  wire isCoil = (code < `DCDM_CODE_ZERO);
  wire isCoilB = (code >= `DCDM_CODE_COILB);
  // Coil bits indexed by low three code bits, then constants and motion
  always_comb begin
    if (isCoil) begin
      bitOut = isCoilB ? coilB[code[2:0]] : coilA[code[2:0]];
    end else if (code == `DCDM_CODE_ZERO) begin
      bitOut = 1'b0;
    end else if (code == `DCDM_CODE_ONE) begin
      bitOut = 1'b1;
    end else if (code == `DCDM_CODE_DIR) begin
      bitOut = motor.direction;
    end else if (code == `DCDM_CODE_STEP) begin
      bitOut = motor.step;
    end else begin
      bitOut = 1'b1;
    end
  end
endmodule

// >>> hdl/dcdm_mux.sv
// Driver chain datagram multiplexer: config memory, snapshot, bit sequencer
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "dcdm_cfg.svh"
module dcdm_mux
  import dcdm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [5:0] cfgAddr,
  input wire logic [5:0] cfgWrData,
  input wire logic cfgWr,
  input wire logic cfgRd,
  output logic [5:0] cfgRdData,
  input wire dcdm_motor_s [2:0] motorSig,
  input wire logic [1:0] last_driver_index,
  input wire logic sendReq,
  input wire logic bitReady,
  output logic bitValid,
  output logic bitData,
  output logic frameLast,
  output logic busy
);
  // Config memory; not reset, host must load it first
  logic [5:0] cfgMem [0:`DCDM_CFG_DEPTH-1];
  dcdm_motor_s [2:0] snap;
  dcdm_state_e state;
  logic [5:0] rdPtr;
  logic [1:0] motorIdx;
  logic [1:0] lastIdx;
  wire dcdm_entry_s entry = dcdm_entry_s'(cfgMem[rdPtr]);
  wire logic selBit;
  // Index 2 is the last motor slot; a larger setting must not index past it
  wire logic atLast = (motorIdx >= lastIdx) || (motorIdx == 2'h2);
  wire logic endFrame = entry.next_motor_flag && atLast;
  wire logic bitTaken = (state == DCDM_SEND) && bitReady;
  // Selector sees only the snapshot of the current motor
  dcdm_select uSel (
    .motor(snap[motorIdx]),
    .code(entry.code),
    .bitOut(selBit)
  );
  // Host access to the config memory, allowed at any time
  always_ff @(posedge mclk) begin
    if (clkEn && cfgWr) begin
      cfgMem[cfgAddr] <= cfgWrData;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfgRdData <= 6'h00;
    end else if (clkEn && cfgRd) begin
      cfgRdData <= cfgMem[cfgAddr];
    end
  end
  // Sequencer: snapshot, then walk memory from location zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= DCDM_IDLE;
      rdPtr <= 6'h00;
      motorIdx <= `DCDM_IDX_RESET;
      lastIdx <= 2'h0;
      snap <= '0;
    end else if (clkEn) begin
      unique case (state)
        DCDM_IDLE: begin
          if (sendReq) begin
            state <= DCDM_SNAP;
          end
        end
        DCDM_SNAP: begin
          snap <= motorSig;
          lastIdx <= last_driver_index;
          rdPtr <= 6'h00;
          motorIdx <= `DCDM_IDX_RESET;
          state <= DCDM_SEND;
        end
        DCDM_SEND: begin
          if (bitTaken) begin
            rdPtr <= rdPtr + 6'h01;
            if (endFrame) begin
              motorIdx <= `DCDM_IDX_RESET;
              state <= DCDM_IDLE;
            end else if (entry.next_motor_flag) begin
              motorIdx <= motorIdx + 2'h1;
            end
          end
        end
      endcase
    end
  end
  // Stream outputs are combinational from registered state and snapshot
  assign bitValid = (state == DCDM_SEND);
  assign bitData = selBit;
  assign frameLast = (state == DCDM_SEND) && endFrame;
  assign busy = (state != DCDM_IDLE);
endmodule

// >>> dv/dcdm_mux_chk.sv
// Handshake checker of the datagram multiplexer
`timescale 1ns/1ps
module dcdm_mux_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sendReq,
  input wire logic bitReady,
  input wire logic bitValid,
  input wire logic bitData,
  input wire logic frameLast,
  input wire logic busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // A request gives one snapshot cycle, then bits
  sequence s_req; sendReq && !busy; endsequence
  sequence s_snap; busy && !bitValid ##1 bitValid; endsequence
  property p_go; s_req |=> s_snap; endproperty
  a_go: assert property (p_go) else $error("no snap");
  property p_snap; busy && !bitValid |=> bitValid; endproperty
  a_snap: assert property (p_snap) else $error("slow");
  property p_idle; !busy && !sendReq |=> !busy; endproperty
  a_idle: assert property (p_idle) else $error("woke");
  property p_end; bitValid && bitReady && frameLast |=> !busy; endproperty
  a_end: assert property (p_end) else $error("no end");
  property p_run; busy && !(bitReady && frameLast) |=> busy; endproperty
  a_run: assert property (p_run) else $error("cut");
  property p_next; bitValid && bitReady && !frameLast |=> bitValid; endproperty
  a_next: assert property (p_next) else $error("gap");
  property p_keep; bitValid && !bitReady |=> $stable(bitData); endproperty
  a_keep: assert property (p_keep) else $error("moved");
  property p_vb; bitValid |-> busy; endproperty
  a_vb: assert property (p_vb) else $error("stray");
  property p_fl; frameLast |-> bitValid; endproperty
  a_fl: assert property (p_fl) else $error("last alone");
endmodule

// >>> dv/dcdm_chain_model.sv
// Driver chain model taking bits with random stalls
`timescale 1ns/1ps
module dcdm_chain_model (
  input wire logic mclk,
  input wire logic rst_b,
  output logic bitReady
);
  // Stalls about one cycle in four to exercise holding
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) bitReady <= 1'b0;
    else bitReady <= ($urandom % 4) != 0;
  end
endmodule

// >>> dv/driver_chain_datagram_mux_bench.sv
// Bench of the driver chain datagram multiplexer
`timescale 1ns/1ps
module driver_chain_datagram_mux_bench;
  import dcdm_pkg::*;
  logic mclk, rst_b, cfgWr, cfgRd, sendReq, bitReady, bitValid, bitData;
  logic frameLast, busy, fl;
  logic rdPend = 1'b0;
  logic [5:0] cfgAddr, cfgWrData, cfgRdData, d;
  logic [5:0] bq[$], rq[$];
  logic [1:0] lastIdx;
  dcdm_motor_s [2:0] motorSig, v;
  int fails, samples_checked, cyc, e, m;
  dcdm_mux dut_u(.mclk, .rst_b, .clkEn(1'b1), .cfgAddr, .cfgWrData, .cfgWr,
    .cfgRd, .cfgRdData, .motorSig, .last_driver_index(lastIdx), .sendReq,
    .bitReady, .bitValid, .bitData, .frameLast, .busy);
  dcdm_chain_model chain_u(.mclk, .rst_b, .bitReady);
  // Reference selector; codes above 19 give a constant one
  function automatic logic pick(dcdm_motor_s s, logic [4:0] c);
    logic [19:0] t;
    t = {s.step, s.direction, 2'b10, s.coil_b_fast_decay, s.coil_b_polarity,
      s.coilBDac, s.coil_a_fast_decay, s.coil_a_polarity, s.coilADac};
    return c > 5'h13 ? 1'b1 : t[c];
  endfunction
  task automatic chk(string n, logic [5:0] x, logic [5:0] s);
    samples_checked++;
    if (x !== s) fails++;
    if (x !== s) $display("FAIL %s exp %h got %h", n, x, s);
  endtask
  task automatic stop_test;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Output watcher pops the oldest note; also cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) fails++;
    if (cyc > 5000) stop_test();
    if (rdPend) chk("rdata", rq.pop_front(), cfgRdData);
    if (bitValid && bitReady) chk("bit", bq.pop_front(),
      {4'h0, frameLast, bitData});
    rdPend <= cfgRd;
  end
  // Load and read back the setup, then send frames for last index 2, 1, 0
  initial begin
    void'($urandom(32'h77164633));
    {rst_b, cfgWr, cfgRd, sendReq, lastIdx} = '0;
    {cfgAddr, cfgWrData, motorSig} = '0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    for (e = 0; e < 40; e++) begin
      d = {e == 12 || e == 25 || e == 39, 5'(e)};
      @(posedge mclk);
      {cfgWr, cfgRd, cfgAddr, cfgWrData} <= {2'b10, 6'(e), d};
      rq.push_back(d);
      @(posedge mclk);
      {cfgWr, cfgRd} <= 2'b01;
    end
    for (int f = 0; f < 3; f++) begin
      v = $bits(v)'({$urandom, $urandom});
      @(posedge mclk);
      {cfgRd, sendReq, lastIdx, motorSig} <= {2'b01, 2'(2 - f), v};
      {m, e} = '0;
      do begin
        fl = e == 12 || e == 25 || e == 39;
        bq.push_back({4'h0, fl && m >= 2 - f, pick(v[m], 5'(e))});
        m += int'(fl);
        e++;
      end while (!(fl && m > 2 - f));
      repeat (2) @(posedge mclk);
      {sendReq, motorSig} <= {1'b0, ~v};
      while (busy || bq.size() > 0) @(posedge mclk);
    end
    stop_test();
  end
endmodule
bind dcdm_mux dcdm_mux_chk chk_u(.mclk, .rst_b, .sendReq, .bitReady,
  .bitValid, .bitData, .frameLast, .busy);
